// ---- src/tpt_buf.sv ----
// Purpose: small fifo with valid/ready on both sides
// Assumes: synchronous active-high reset
// Notes: no bypass, so a written word shows one cycle later
`timescale 1ns/1ps
module tpt_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [W-1:0] IN_DATA_I,
  input wire logic IN_VALID_I,
  output logic IN_READY_O,
  output logic [W-1:0] OUT_DATA_O,
  output logic OUT_VALID_O,
  input wire logic OUT_READY_I
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  generate
    if (DEPTH < 2 || W < 1) begin : g_bad
      $error("tpt_buf needs DEPTH of two or more and W of one or more");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } tpt_buf_state_t;

  tpt_buf_state_t r;
  tpt_buf_state_t n;
  logic push;
  logic pop;
  logic [AW:0] sum;
  logic [AW:0] wr;

  assign IN_READY_O = (r.cnt != DEPTH_C);
  assign OUT_VALID_O = (r.cnt != '0);
  assign OUT_DATA_O = r.mem[r.rd];
  assign push = IN_VALID_I && IN_READY_O;
  assign pop = OUT_VALID_O && OUT_READY_I;
  assign sum = {1'b0, r.rd} + r.cnt;
  assign wr = (sum >= DEPTH_C) ? (sum - DEPTH_C) : sum;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[wr[AW-1:0]] = IN_DATA_I;
    end
    if (pop) begin
      n.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + AW'(1);
    end
    if (push && !pop) begin
      n.cnt = r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      n.cnt = r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : tpt_buf

// ---- src/tpt_card.sv ----
// Purpose: card end of the character transport sequencer
// Assumes: the card application answers each header and body request
// Notes: header and body bytes arrive through a two-entry buffer
`timescale 1ns/1ps
`include "tpt_consts.svh"

module tpt_card
  import tpt_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  tpt_link_if.card link,
  output logic [39:0] HDR_O,
  output logic HDR_VALID_O,
  output logic END_REQ_O,
  input wire logic RSP_VALID_I,
  input wire logic RSP_OK_I,
  input wire tpt_pkg::tpt_case_t RSP_CASE_I,
  input wire logic [15:0] RSP_SW_I,
  input wire logic [8:0] RSP_AVAIL_I,
  output logic [7:0] BODY_DATA_O,
  output logic BODY_VALID_O,
  input wire logic BODY_READY_I,
  input wire logic [7:0] TXD_I,
  input wire logic TXD_VALID_I,
  output logic TXD_READY_O
);
  import tpt_pkg::*;

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  tpt_card_state_t r;
  tpt_card_state_t n;
  logic tx_free;
  logic [8:0] le9;
  logic [8:0] rem;
  logic [7:0] buf_data;
  logic buf_valid;
  logic buf_ready;
  logic rx_take;

  assign tx_free = !r.tx_valid || link.c2t_ready;
  // zero in the length byte stands for the full 256
  assign le9 = (r.hdr[`TPT_HDR_LEN] == 8'h00) ? `TPT_LEN_ZERO_MEANS
                                               : {1'b0, r.hdr[`TPT_HDR_LEN]};
  assign rem = RSP_AVAIL_I - le9;

  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------
  // lets the terminal keep sending while the application stalls the body
  tpt_buf #(
    .W(8),
    .DEPTH(`TPT_BUF_DEPTH)
  ) u_rx_buf (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .IN_DATA_I(link.t2c_data),
    .IN_VALID_I(link.t2c_valid),
    .IN_READY_O(link.t2c_ready),
    .OUT_DATA_O(buf_data),
    .OUT_VALID_O(buf_valid),
    .OUT_READY_I(buf_ready)
  );

  assign buf_ready = (r.st == CS_HDR) || ((r.st == CS_BODY) && BODY_READY_I);
  assign rx_take = buf_valid && buf_ready;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    if (r.tx_valid && link.c2t_ready) begin
      n.tx_valid = 1'b0;
    end
    unique case (r.st)
      CS_HDR: begin
        if (rx_take) begin
          n.hdr[r.cnt[2:0]] = buf_data;
          if (r.cnt[2:0] == `TPT_HDR_LEN) begin
            n.st = CS_DECIDE;
            n.cnt = '0;
          end else begin
            n.cnt = r.cnt + 9'h001;
          end
        end
      end
      CS_DECIDE: begin
        if (RSP_VALID_I) begin
          // the application classifies the header, zero length included
          n.cas = RSP_CASE_I;
          if (!RSP_OK_I) begin
            // abnormal processing: status only
            n.sw = RSP_SW_I;
            n.st = CS_SW1;
          end else begin
            unique case (RSP_CASE_I)
              TPT_CASE1: begin
                n.sw = `TPT_SW_OK;
                n.st = CS_SW1;
              end
              TPT_CASE3, TPT_CASE4: begin
                n.cnt = le9;
                n.st = CS_ACK;
              end
              TPT_CASE2: begin
                if (le9 > RSP_AVAIL_I) begin
                  // asks for more than there is, or zero with under 256
                  n.sw = {`TPT_PB_RELEN, RSP_AVAIL_I[7:0]};
                  n.st = CS_SW1;
                end else if (le9 == RSP_AVAIL_I) begin
                  n.sw = `TPT_SW_OK;
                  n.cnt = le9;
                  n.st = CS_ACK;
                end else begin
                  // remainder offered after the data
                  n.sw = {`TPT_PB_MORE, rem[7:0]};
                  n.cnt = le9;
                  n.st = CS_ACK;
                end
              end
            endcase
          end
        end
      end
      CS_ACK: begin
        if (tx_free) begin
          n.tx_data = r.hdr[`TPT_HDR_INS];
          n.tx_valid = 1'b1;
          n.st = (r.cas == TPT_CASE2) ? CS_DATA : CS_BODY;
        end
      end
      CS_BODY: begin
        if (rx_take) begin
          n.cnt = r.cnt - 9'h001;
          if (r.cnt == 9'h001) begin
            n.st = CS_WAIT_END;
          end
        end
      end
      CS_WAIT_END: begin
        if (RSP_VALID_I) begin
          if (!RSP_OK_I) begin
            n.sw = RSP_SW_I;
          end else if (r.cas == TPT_CASE4) begin
            // avail of 256 goes out as 00, the full-length code
            n.sw = {`TPT_PB_MORE, RSP_AVAIL_I[7:0]};
          end else begin
            n.sw = `TPT_SW_OK;
          end
          n.st = CS_SW1;
        end
      end
      CS_DATA: begin
        if (TXD_VALID_I && tx_free) begin
          n.tx_data = TXD_I;
          n.tx_valid = 1'b1;
          n.cnt = r.cnt - 9'h001;
          if (r.cnt == 9'h001) begin
            n.st = CS_SW1;
          end
        end
      end
      CS_SW1: begin
        if (tx_free) begin
          n.tx_data = r.sw[15:8];
          n.tx_valid = 1'b1;
          n.st = CS_SW2;
        end
      end
      CS_SW2: begin
        if (tx_free) begin
          n.tx_data = r.sw[7:0];
          n.tx_valid = 1'b1;
          n.cnt = '0;
          n.st = CS_HDR;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign HDR_O = r.hdr;
  assign HDR_VALID_O = (r.st == CS_DECIDE);
  assign END_REQ_O = (r.st == CS_WAIT_END);
  assign BODY_DATA_O = buf_data;
  assign BODY_VALID_O = (r.st == CS_BODY) && buf_valid;
  assign TXD_READY_O = (r.st == CS_DATA) && tx_free;
  assign link.c2t_data = r.tx_data;
  assign link.c2t_valid = r.tx_valid;
endmodule : tpt_card

// ---- src/tpt_consts.svh ----
// Purpose: byte codes and fixed counts of the character transport
// Assumes: included by its bare name from the modules
// Notes: definitions only
`ifndef TPT_CONSTS_SVH
`define TPT_CONSTS_SVH

// ----------------------------------------------------------------
// procedure bytes and status words
// ----------------------------------------------------------------
`define TPT_PB_NULL 8'h60
`define TPT_PB_MORE 8'h61
`define TPT_PB_RELEN 8'h6C
`define TPT_SW1_WARN_A 8'h62
`define TPT_SW1_WARN_B 8'h63
`define TPT_SW1_APP_HI 4'h9
`define TPT_SW_OK 16'h9000

// ----------------------------------------------------------------
// retrieval command header
// ----------------------------------------------------------------
`define TPT_INS_GET_RESP 8'hC0
`define TPT_GR_PARAM 8'h00

// ----------------------------------------------------------------
// header layout and counts
// ----------------------------------------------------------------
`define TPT_HDR_CLA 3'h0
`define TPT_HDR_INS 3'h1
`define TPT_HDR_P1 3'h2
`define TPT_HDR_P2 3'h3
`define TPT_HDR_LEN 3'h4
`define TPT_LEN_ZERO_MEANS 9'h100
`define TPT_BUF_DEPTH 2

`endif

// ---- src/tpt_link_if.sv ----
// Purpose: byte link between terminal end and card end
// Assumes: one clock, valid/ready per direction
// Notes: a byte moves on a rising edge with valid and ready high
`timescale 1ns/1ps
interface tpt_link_if;
  logic [7:0] t2c_data;
  logic t2c_valid;
  logic t2c_ready;
  logic [7:0] c2t_data;
  logic c2t_valid;
  logic c2t_ready;

  modport card (
    input t2c_data,
    input t2c_valid,
    output t2c_ready,
    output c2t_data,
    output c2t_valid,
    input c2t_ready
  );

  modport term (
    output t2c_data,
    output t2c_valid,
    input t2c_ready,
    input c2t_data,
    input c2t_valid,
    output c2t_ready
  );
endinterface : tpt_link_if

// ---- src/tpt_pkg.sv ----
// Purpose: shared types of both transport ends
// Assumes: tpt_consts.svh holds the numbers
// Notes: reset value of every state struct is all zeros
package tpt_pkg;

  typedef enum logic [1:0] {
    TPT_CASE1 = 2'b00,
    TPT_CASE2 = 2'b01,
    TPT_CASE3 = 2'b10,
    TPT_CASE4 = 2'b11
  } tpt_case_t;

  typedef enum logic [2:0] {
    CS_HDR = 3'b000,
    CS_DECIDE = 3'b001,
    CS_ACK = 3'b010,
    CS_BODY = 3'b011,
    CS_WAIT_END = 3'b100,
    CS_DATA = 3'b101,
    CS_SW1 = 3'b110,
    CS_SW2 = 3'b111
  } tpt_card_st_t;

  typedef enum logic [2:0] {
    TS_IDLE = 3'b000,
    TS_HDR = 3'b001,
    TS_PROC = 3'b010,
    TS_PROC2 = 3'b011,
    TS_BODY = 3'b100,
    TS_RDATA = 3'b101
  } tpt_term_st_t;

  typedef struct packed {
    tpt_card_st_t st;
    logic [8:0] cnt;
    logic [4:0][7:0] hdr;
    tpt_case_t cas;
    logic [15:0] sw;
    logic [7:0] tx_data;
    logic tx_valid;
  } tpt_card_state_t;

  typedef struct packed {
    tpt_term_st_t st;
    logic [8:0] cnt;
    logic [4:0][7:0] hdr;
    tpt_case_t cas;
    logic [7:0] lc;
    logic [7:0] sb1;
    logic body_sent;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [7:0] rx_data;
    logic rx_valid;
    logic [15:0] sw;
    logic done;
  } tpt_term_state_t;

endpackage : tpt_pkg

// ---- src/tpt_term.sv ----
// Purpose: terminal end of the character transport sequencer
// Assumes: user holds command fields stable while CMD_VALID_I is high
// Notes: received data is never back-pressured
`timescale 1ns/1ps
`include "tpt_consts.svh"
module tpt_term
  import tpt_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  tpt_link_if.term link,
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire logic [31:0] CMD_HDR_I,
  input wire tpt_pkg::tpt_case_t CMD_CASE_I,
  input wire logic [7:0] CMD_LC_I,
  input wire logic [7:0] CMD_LE_I,
  input wire logic [7:0] TXD_I,
  input wire logic TXD_VALID_I,
  output logic TXD_READY_O,
  output logic [7:0] RXD_O,
  output logic RXD_VALID_O,
  output logic [15:0] SW_O,
  output logic DONE_O
);
  import tpt_pkg::*;

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  tpt_term_state_t r;
  tpt_term_state_t n;
  logic tx_free;
  logic rx_take;
  logic [7:0] b;
  logic sends_body;
  logic retry_sw;

  assign tx_free = !r.tx_valid || link.t2c_ready;
  assign link.c2t_ready = (r.st == TS_PROC) || (r.st == TS_PROC2) || (r.st == TS_RDATA);
  assign rx_take = link.c2t_valid && link.c2t_ready;
  assign b = link.c2t_data;
  assign sends_body = (CMD_CASE_I == TPT_CASE3) || (CMD_CASE_I == TPT_CASE4);
  // warning or application status other than success
  assign retry_sw = (r.sb1 == `TPT_SW1_WARN_A) || (r.sb1 == `TPT_SW1_WARN_B)
                    || ((r.sb1[7:4] == `TPT_SW1_APP_HI) && ({r.sb1, b} != `TPT_SW_OK));

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.rx_valid = 1'b0;
    n.done = 1'b0;
    if (r.tx_valid && link.t2c_ready) begin
      n.tx_valid = 1'b0;
    end
    unique case (r.st)
      TS_IDLE: begin
        if (CMD_VALID_I && CMD_READY_O) begin
          n.hdr[`TPT_HDR_CLA] = CMD_HDR_I[31:24];
          n.hdr[`TPT_HDR_INS] = CMD_HDR_I[23:16];
          n.hdr[`TPT_HDR_P1] = CMD_HDR_I[15:8];
          n.hdr[`TPT_HDR_P2] = CMD_HDR_I[7:0];
          // expected length never goes out with a body
          n.hdr[`TPT_HDR_LEN] = sends_body ? CMD_LC_I
                              : (CMD_CASE_I == TPT_CASE2) ? CMD_LE_I : 8'h00;
          n.cas = CMD_CASE_I;
          n.lc = CMD_LC_I;
          n.body_sent = 1'b0;
          n.cnt = '0;
          n.st = TS_HDR;
        end
      end
      TS_HDR: begin
        if (tx_free) begin
          n.tx_data = r.hdr[r.cnt[2:0]];
          n.tx_valid = 1'b1;
          n.cnt = r.cnt + 9'h001;
          if (r.cnt[2:0] == `TPT_HDR_LEN) begin
            n.st = TS_PROC;
          end
        end
      end
      TS_PROC: begin
        if (rx_take && (b != `TPT_PB_NULL)) begin
          if (b == r.hdr[`TPT_HDR_INS]) begin
            if (((r.cas == TPT_CASE3) || (r.cas == TPT_CASE4)) && !r.body_sent) begin
              n.cnt = {1'b0, r.lc};
              n.st = TS_BODY;
            end else begin
              n.cnt = (r.hdr[`TPT_HDR_LEN] == 8'h00) ? `TPT_LEN_ZERO_MEANS
                                                     : {1'b0, r.hdr[`TPT_HDR_LEN]};
              n.st = TS_RDATA;
            end
          end else begin
            n.sb1 = b;
            n.st = TS_PROC2;
          end
        end
      end
      TS_BODY: begin
        if (TXD_VALID_I && tx_free) begin
          n.tx_data = TXD_I;
          n.tx_valid = 1'b1;
          n.cnt = r.cnt - 9'h001;
          if (r.cnt == 9'h001) begin
            n.body_sent = 1'b1;
            n.st = TS_PROC;
          end
        end
      end
      TS_RDATA: begin
        if (rx_take) begin
          n.rx_data = b;
          n.rx_valid = 1'b1;
          n.cnt = r.cnt - 9'h001;
          if (r.cnt == 9'h001) begin
            n.st = TS_PROC;
          end
        end
      end
      TS_PROC2: begin
        if (rx_take) begin
          n.cnt = '0;
          if (r.sb1 == `TPT_PB_MORE) begin
            n.hdr[`TPT_HDR_INS] = `TPT_INS_GET_RESP;
            n.hdr[`TPT_HDR_P1] = `TPT_GR_PARAM;
            n.hdr[`TPT_HDR_P2] = `TPT_GR_PARAM;
            n.hdr[`TPT_HDR_LEN] = b;
            n.cas = TPT_CASE2;
            n.st = TS_HDR;
          end else if (r.sb1 == `TPT_PB_RELEN) begin
            n.hdr[`TPT_HDR_LEN] = b;
            n.st = TS_HDR;
          end else if ((r.cas == TPT_CASE4) && r.body_sent && retry_sw) begin
            n.sw = {r.sb1, b};
            n.hdr[`TPT_HDR_INS] = `TPT_INS_GET_RESP;
            n.hdr[`TPT_HDR_P1] = `TPT_GR_PARAM;
            n.hdr[`TPT_HDR_P2] = `TPT_GR_PARAM;
            n.hdr[`TPT_HDR_LEN] = 8'h00;
            n.cas = TPT_CASE2;
            n.st = TS_HDR;
          end else begin
            n.sw = {r.sb1, b};
            n.done = 1'b1;
            n.st = TS_IDLE;
          end
        end
      end
      default: begin
        n.st = TS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a body command with zero length is refused
  assign CMD_READY_O = (r.st == TS_IDLE) && !(sends_body && (CMD_LC_I == 8'h00));
  assign TXD_READY_O = (r.st == TS_BODY) && tx_free;
  assign RXD_O = r.rx_data;
  assign RXD_VALID_O = r.rx_valid;
  assign SW_O = r.sw;
  assign DONE_O = r.done;
  assign link.t2c_data = r.tx_data;
  assign link.t2c_valid = r.tx_valid;
endmodule : tpt_term

// ---- tb/t0_apdu_transport_bench.sv ----
// Purpose: runs whole command exchanges through terminal and card ends
// Assumes: the card application is modelled here and answers one cycle after each request
// Notes: data and body bytes are running counts checked in order
`timescale 1ns/1ps
`include "tpt_consts.svh"
`define TB_CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module t0_apdu_transport_bench;
  import tpt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  tpt_case_t cmd_case = TPT_CASE1;
  logic [7:0] cmd_lc = 8'h00;
  logic [7:0] cmd_le = 8'h00;
  logic [7:0] tt_data = 8'h00;
  logic tt_ready;
  logic [7:0] rxd;
  logic rxd_valid;
  logic [15:0] sw;
  logic done;
  logic [39:0] hdr;
  logic hdr_valid;
  logic end_req;
  logic rsp_valid = 1'b0;
  logic rsp_ok = 1'b0;
  tpt_case_t rsp_case = TPT_CASE1;
  logic [15:0] rsp_sw = 16'h0000;
  logic [8:0] rsp_avail = 9'h000;
  logic [7:0] body_data;
  logic body_valid;
  logic body_ready = 1'b0;
  logic [7:0] ct_data = 8'h00;
  logic ct_ready;
  logic src_valid = 1'b0;
  tpt_case_t t_case = TPT_CASE1;
  logic [15:0] t_hsw = 16'h0000;
  logic [15:0] t_esw = 16'h0000;
  logic [7:0] t_len = 8'h00;
  logic [8:0] avail_left = 9'h000;
  logic [7:0] rx_exp = 8'h00;
  logic [7:0] body_exp = 8'h00;
  logic gr;
  bit hdr_chk = 1'b0;
  int rx_n = 0;
  int body_n = 0;
  int cyc = 0;
  int fail_count = 0;
  int checks_done = 0;
  always #10 clk_i = ~clk_i;
  assign gr = hdr[15:8] == `TPT_INS_GET_RESP;

  tpt_link_if link ();
  tpt_card i_tpt_card (.CLK_I(clk_i), .RST_I(rst_i), .link(link.card), .HDR_O(hdr),
    .HDR_VALID_O(hdr_valid), .END_REQ_O(end_req), .RSP_VALID_I(rsp_valid), .RSP_OK_I(rsp_ok),
    .RSP_CASE_I(rsp_case), .RSP_SW_I(rsp_sw), .RSP_AVAIL_I(rsp_avail), .BODY_DATA_O(body_data),
    .BODY_VALID_O(body_valid), .BODY_READY_I(body_ready), .TXD_I(ct_data), .TXD_VALID_I(src_valid),
    .TXD_READY_O(ct_ready));
  tpt_term i_tpt_term (.CLK_I(clk_i), .RST_I(rst_i), .link(link.term), .CMD_VALID_I(cmd_valid),
    .CMD_READY_O(cmd_ready), .CMD_HDR_I(32'h80B01234), .CMD_CASE_I(cmd_case), .CMD_LC_I(cmd_lc),
    .CMD_LE_I(cmd_le), .TXD_I(tt_data), .TXD_VALID_I(src_valid), .TXD_READY_O(tt_ready),
    .RXD_O(rxd), .RXD_VALID_O(rxd_valid), .SW_O(sw), .DONE_O(done));
  tpt_link_props i_tpt_link_props (.clk_i(clk_i), .rst_i(rst_i), .t2c_data(link.t2c_data),
    .t2c_valid(link.t2c_valid), .t2c_ready(link.t2c_ready), .c2t_data(link.c2t_data),
    .c2t_valid(link.c2t_valid), .c2t_ready(link.c2t_ready));

  // --------------------------------------------------------------
  // card application model and byte sinks
  // --------------------------------------------------------------
  // sink stalls three cycles in four so the card buffer fills up
  // sources drop valid one cycle in eight so both senders must wait
  always @(posedge clk_i) begin
    cyc++;
    body_ready <= #1 (cyc[1:0] == 2'h3);
    src_valid <= #1 (cyc[2:0] != 3'h5);
    rsp_valid <= #1 (hdr_valid || end_req) && !rsp_valid;
    rsp_ok <= #1 hdr_valid ? (gr || t_hsw == 16'h0000) : (t_esw == 16'h0000);
    rsp_sw <= #1 hdr_valid ? t_hsw : t_esw;
    rsp_case <= #1 gr ? TPT_CASE2 : t_case;
    rsp_avail <= #1 avail_left;
    if (hdr_valid && !hdr_chk) `TB_CHK("header", {t_len, 32'h3412B080}, hdr)
    if (hdr_valid) hdr_chk = 1'b1;
    if (ct_ready && src_valid) ct_data <= #1 ct_data + 8'h01;
    if (ct_ready && src_valid) avail_left <= #1 avail_left - 9'h001;
    if (tt_ready && src_valid) tt_data <= #1 tt_data + 8'h01;
    if (rxd_valid) `TB_CHK("rx data", rx_exp, rxd)
    if (rxd_valid) rx_exp++;
    if (rxd_valid) rx_n++;
    if (body_valid && body_ready) `TB_CHK("body data", body_exp, body_data)
    if (body_valid && body_ready) body_exp++;
    if (body_valid && body_ready) body_n++;
  end

  task automatic run_cmd(input tpt_case_t cas, input logic [7:0] lc, input logic [7:0] le,
      input logic [15:0] hsw, input logic [8:0] av, input logic [15:0] esw,
      input logic [15:0] exp_sw, input int exp_rx);
    int n;
    t_case = cas;
    t_hsw = hsw;
    t_esw = esw;
    t_len = (cas >= TPT_CASE3) ? lc : le;
    avail_left = av;
    rx_n = 0;
    body_n = 0;
    hdr_chk = 1'b0;
    cmd_case = cas;
    cmd_lc = lc;
    cmd_le = le;
    cmd_valid = 1'b1;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    if (n >= 50) begin
      fail_count++;
      final_report();
    end
    @(posedge clk_i);
    #1 cmd_valid = 1'b0;
    for (n = n; n < 3000 && done !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    if (n >= 3000) begin
      fail_count++;
      final_report();
    end
    `TB_CHK("status", exp_sw, sw)
    `TB_CHK("rx count", exp_rx, rx_n)
    `TB_CHK("body count", (cas >= TPT_CASE3 && hsw == 16'h0) ? int'(lc) : 0, body_n)
    @(posedge clk_i);
    #1;
  endtask : run_cmd

  task final_report;
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    run_cmd(TPT_CASE1, 8'h00, 8'h00, 16'h0, 9'h000, 16'h0, 16'h9000, 0);
    run_cmd(TPT_CASE1, 8'h00, 8'h00, 16'h6A82, 9'h000, 16'h0, 16'h6A82, 0);
    run_cmd(TPT_CASE2, 8'h00, 8'h04, 16'h0, 9'h004, 16'h0, 16'h9000, 4);
    run_cmd(TPT_CASE2, 8'h00, 8'h08, 16'h0, 9'h004, 16'h0, 16'h9000, 4);
    run_cmd(TPT_CASE2, 8'h00, 8'h00, 16'h0, 9'h003, 16'h0, 16'h9000, 3);
    run_cmd(TPT_CASE2, 8'h00, 8'h00, 16'h0, 9'h100, 16'h0, 16'h9000, 256);
    run_cmd(TPT_CASE2, 8'h00, 8'h02, 16'h0, 9'h005, 16'h0, 16'h9000, 5);
    run_cmd(TPT_CASE2, 8'h00, 8'h02, 16'h6A86, 9'h005, 16'h0, 16'h6A86, 0);
    run_cmd(TPT_CASE3, 8'hFF, 8'h00, 16'h0, 9'h000, 16'h0, 16'h9000, 0);
    run_cmd(TPT_CASE3, 8'h01, 8'h00, 16'h6985, 9'h000, 16'h0, 16'h6985, 0);
    run_cmd(TPT_CASE3, 8'h03, 8'h00, 16'h0, 9'h000, 16'h6A80, 16'h6A80, 0);
    run_cmd(TPT_CASE4, 8'h02, 8'h00, 16'h0, 9'h006, 16'h0, 16'h9000, 6);
    run_cmd(TPT_CASE4, 8'h02, 8'h00, 16'h0, 9'h002, 16'h6283, 16'h9000, 2);
    run_cmd(TPT_CASE4, 8'h01, 8'h00, 16'h0, 9'h001, 16'h9101, 16'h9000, 1);
    run_cmd(TPT_CASE4, 8'h01, 8'h00, 16'h0, 9'h002, 16'h6A80, 16'h6A80, 0);
    final_report();
  end
endmodule : t0_apdu_transport_bench

// ---- tb/tpt_link_properties.sv ----
// Purpose: watches the byte link between terminal and card ends
// Assumes: one clock, synchronous active-high reset
// Notes: a small tracker follows header, body, data and status pairs
`timescale 1ns/1ps
module tpt_link_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] t2c_data,
  input wire logic t2c_valid,
  input wire logic t2c_ready,
  input wire logic [7:0] c2t_data,
  input wire logic c2t_valid,
  input wire logic c2t_ready
);
  logic t2c_fire;
  logic c2t_fire;
  logic await_sw;
  logic [2:0] hcnt_reg;
  logic [8:0] dcnt_reg;
  logic [7:0] ins_reg;
  logic [7:0] len_reg;
  logic pend_reg;
  logic [7:0] sw1_reg;
  logic [7:0] last1_reg;
  logic [7:0] last2_reg;
  assign t2c_fire = t2c_valid && t2c_ready;
  assign c2t_fire = c2t_valid && c2t_ready;
  assign await_sw = hcnt_reg == 3'h5 && dcnt_reg == 9'h000 && !pend_reg;

  // --------------------------------------------------------------
  // exchange tracker
  // --------------------------------------------------------------
  // a lone byte equal to the stored instruction opens the data phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hcnt_reg <= 3'h0;
      dcnt_reg <= 9'h000;
      pend_reg <= 1'b0;
      last1_reg <= 8'h00;
    end else if (t2c_fire && hcnt_reg < 3'h5) begin
      hcnt_reg <= hcnt_reg + 3'h1;
      if (hcnt_reg == 3'h1) ins_reg <= t2c_data;
      if (hcnt_reg == 3'h4) len_reg <= t2c_data;
    end else if (t2c_fire || (c2t_fire && dcnt_reg != 9'h000)) begin
      dcnt_reg <= dcnt_reg - 9'h001;
    end else if (c2t_fire && pend_reg) begin
      pend_reg <= 1'b0;
      hcnt_reg <= 3'h0;
      last1_reg <= sw1_reg;
      last2_reg <= c2t_data;
    end else if (c2t_fire && c2t_data == ins_reg) begin
      dcnt_reg <= {len_reg == 8'h00, len_reg};
    end else if (c2t_fire && c2t_data != 8'h60) begin
      pend_reg <= 1'b1;
      sw1_reg <= c2t_data;
    end
  end

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  t2c_hold_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    t2c_valid && !t2c_ready |=> t2c_valid && $stable(t2c_data)) else $error("t2c byte moved");
  c2t_hold_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    c2t_valid && !c2t_ready |=> c2t_valid && $stable(c2t_data)) else $error("c2t byte moved");
  body_gate_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    t2c_fire |-> hcnt_reg < 3'h5 || dcnt_reg != 9'h000) else $error("t2c byte out of turn");
  answer_after_hdr_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    c2t_fire |-> hcnt_reg == 3'h5) else $error("card spoke before full header");
  answer_bound_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(await_sw) |-> ##[1:60] c2t_valid) else $error("card gave no answer");
  gr_ins_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    t2c_fire && hcnt_reg == 3'h1 && last1_reg == 8'h61 |-> t2c_data == 8'hC0)
    else $error("retrieval header lacks its instruction");
  gr_len_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    t2c_fire && hcnt_reg == 3'h4 && last1_reg == 8'h61 |-> t2c_data <= last2_reg)
    else $error("retrieval length above offer");
  relen_len_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    t2c_fire && hcnt_reg == 3'h4 && last1_reg == 8'h6C |-> t2c_data == last2_reg)
    else $error("resent header length wrong");
  relen_ins_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    t2c_fire && hcnt_reg == 3'h1 && last1_reg == 8'h6C |-> t2c_data == ins_reg)
    else $error("resent header instruction wrong");
  cover property (@(posedge clk_i) t2c_fire && hcnt_reg == 3'h1 && last1_reg == 8'h61);
  cover property (@(posedge clk_i) t2c_fire && hcnt_reg == 3'h1 && last1_reg == 8'h6C);
  cover property (@(posedge clk_i) t2c_fire && !t2c_ready == 1'b0 && dcnt_reg == 9'h001);
endmodule : tpt_link_props
